/* File: core/posm_pin3_mux.sv */
// pin3 output source mux with apb register access
//
// Contract
// - source field picks rx, status or tx
// - rx select 0-3 forwards remote gpio
// - rx select 4-7: lock, pass, fv, lv
// - status select 0 drives local level
// - status select 1: or of lock
// - status select 2,3: and of pass
// - status select 4 frame sync, rest reserved
// - tx select 0 and pass, 1 or
// - tx select 2 frame, 3 line valid
// - tx select 4 multi-port synchronized
// - tx select 5 interrupt, 111 reserved
// - local level bit sets driven level
// - drive enable bit, resets to zero
// - select bits 7:5, source 4:2, reset zero
`timescale 1ns/1ps
module posm_pin3_mux (
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST,
  // apb slave
  input  wire posm_pkg::posm_apb_req_t APB_REQ,
  output wire posm_pkg::posm_apb_rsp_t APB_RSP,
  // status sources, same clock domain
  input  wire posm_pkg::posm_rx_t      [3:0] RX_STAT,
  input  wire posm_pkg::posm_tx_t      [1:0] TX_STAT,
  input  wire logic                    FRAME_SYNC,
  // two-way pin 3
  input  wire logic                    PIN3_IN,
  output wire logic                    PIN3_OUT,
  output wire logic                    PIN3_OE_N
);
  import posm_pkg::*;

  // state
  // every flop of the block outside the synchroniser sits in one struct, so the reset
  // branch and the next-state logic cannot drift apart
  posm_state_t st_ff;    // all registered state but the synchroniser's
  posm_state_t nxt_st;   // next value of the state

  // filtered pin level from the synchroniser
  logic        pin_level;

  // decoded control fields
  logic [2:0]  sel;       // signal select
  logic [2:0]  src;       // source select
  logic        lvl;       // local level bit
  logic        en;        // drive enable bit

  // per port status gathered into vectors
  logic [3:0]  lock_v;    // lock of each rx port
  logic [3:0]  pass_v;    // pass of each rx port

  // mux result before the output flop
  logic        mux_lvl;   // level chosen by source and select
  logic        mux_rsv;   // a reserved code is programmed

  // apb decode
  logic        acc;       // access phase, answer not yet given
  logic        done;      // the cycle the master sees pready
  logic        hit_ctrl;  // address is the control register
  logic        hit_cfg;   // address is the port configuration
  logic        hit_stat;  // address is the status register
  logic        hit_any;   // any mapped register

  // selected transmit port and its rx selection
  posm_tx_t    tx_s;      // status of the chosen tx port
  logic [3:0]  tx_m;      // rx ports feeding that tx port

  // pin input synchroniser
  // the filtered level only feeds the status word; nothing in
  // the output path depends on it
  // the pin may be driven from off chip when the driver is off,
  // so its level crosses in through three flops
  posm_sync3 u_sync (
    .clk   (CLK),
    .rst   (RST),
    .d_in  (PIN3_IN),
    .q_out (pin_level)
  );

  // field decode
  // plain wires into the registered control byte, so the mux
  // below sees the fields with no extra delay
  // fields sit at their fixed positions in the control byte
  assign sel = st_ff.ctrl[SEL_HI:SEL_LO];
  assign src = st_ff.ctrl[SRC_HI:SRC_LO];
  assign lvl = st_ff.ctrl[LVL_BIT];
  assign en  = st_ff.ctrl[EN_BIT];

  // gather lock and pass into vectors
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lock_v[i] = RX_STAT[i].lock;
      pass_v[i] = RX_STAT[i].pass;
    end
  end

  // pick the tx port status and its rx mask from the source lsb
  always_comb begin
    if (src == SRC_TX1) begin
      tx_s = TX_STAT[1];
      tx_m = st_ff.tx1_sel;
    end else begin
      tx_s = TX_STAT[0];
      tx_m = st_ff.tx0_sel;
    end
  end

  // output source mux
  // one level per cycle; the result is registered below, so a
  // source change shows on the pin one clock later
  // reserved codes drive low and raise a status flag; a stuck
  // low level is safer on a board than a floating pattern
  always_comb begin
    mux_lvl = 1'b0;
    mux_rsv = 1'b0;
    if (!src[2]) begin
      // one of the four receive ports
      case (sel)
        SEL_0,
        SEL_1,
        SEL_2,
        SEL_3: begin
          // forwarded remote gpio value
          mux_lvl = RX_STAT[src[1:0]].remote_gpio[sel[1:0]];
        end
        SEL_4: begin
          mux_lvl = RX_STAT[src[1:0]].lock;
        end
        SEL_5: begin
          mux_lvl = RX_STAT[src[1:0]].pass;
        end
        SEL_6: begin
          mux_lvl = RX_STAT[src[1:0]].frame_valid;
        end
        default: begin
          mux_lvl = RX_STAT[src[1:0]].line_valid;
        end
      endcase
    end else if (src == SRC_DEV) begin
      // device status group
      case (sel)
        SEL_0: begin
          mux_lvl = lvl;
        end
        SEL_1: begin
          mux_lvl = masked_or(lock_v, st_ff.rx_en);
        end
        SEL_2,
        SEL_3: begin
          mux_lvl = masked_and(pass_v, st_ff.rx_en);
        end
        SEL_4: begin
          mux_lvl = FRAME_SYNC;
        end
        default: begin
          mux_rsv = 1'b1;
        end
      endcase
    end else if (src == SRC_RSV) begin
      // undefined source; the host must avoid it
      mux_rsv = 1'b1;
    end else begin
      // one of the two transmit ports
      case (sel)
        SEL_0: begin
          mux_lvl = masked_and(pass_v, tx_m);
        end
        SEL_1: begin
          mux_lvl = masked_or(pass_v, tx_m);
        end
        SEL_2: begin
          mux_lvl = tx_s.frame_valid;
        end
        SEL_3: begin
          mux_lvl = tx_s.line_valid;
        end
        SEL_4: begin
          mux_lvl = tx_s.synced;
        end
        SEL_5: begin
          mux_lvl = tx_s.irq;
        end
        default: begin
          // 110 is unlisted, 111 reserved
          mux_rsv = 1'b1;
        end
      endcase
    end
  end

  // apb decode
  // the slave answers on a fixed schedule and never stretches
  // an access beyond its single wait state
  // one wait state: pready rises on the second access cycle
  assign acc  = APB_REQ.psel & APB_REQ.penable & ~st_ff.rsp.pready;
  assign done = APB_REQ.psel & APB_REQ.penable & st_ff.rsp.pready;

  // address compare, word aligned only
  always_comb begin
    hit_ctrl = 1'b0;
    hit_cfg  = 1'b0;
    hit_stat = 1'b0;
    if (APB_REQ.paddr == byte_addr(IDX_CTRL)) begin
      hit_ctrl = 1'b1;
    end else if (APB_REQ.paddr == byte_addr(IDX_PORTCFG)) begin
      hit_cfg = 1'b1;
    end else if (APB_REQ.paddr == byte_addr(IDX_STATUS)) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any = hit_ctrl | hit_cfg | hit_stat;

  // next state
  // register writes, read answers and the pin flops are all
  // computed here from the current state and the inputs
  always_comb begin
    nxt_st = st_ff;

    // answer flops default to idle each cycle
    nxt_st.rsp.pready  = 1'b0;
    nxt_st.rsp.pslverr = 1'b0;
    nxt_st.rsp.prdata  = '0;

    // prepare the answer one cycle into the access phase
    if (acc) begin
      nxt_st.rsp.pready  = 1'b1;
      // unmapped addresses read zero and flag an error
      nxt_st.rsp.pslverr = ~hit_any;
      if (!APB_REQ.pwrite) begin
        if (hit_ctrl) begin
          nxt_st.rsp.prdata[7:0] = st_ff.ctrl;
        end else if (hit_cfg) begin
          nxt_st.rsp.prdata[RXEN_LO +: 4]   = st_ff.rx_en;
          nxt_st.rsp.prdata[TX0SEL_LO +: 4] = st_ff.tx0_sel;
          nxt_st.rsp.prdata[TX1SEL_LO +: 4] = st_ff.tx1_sel;
        end else if (hit_stat) begin
          nxt_st.rsp.prdata[ST_PIN_IN]  = pin_level;
          nxt_st.rsp.prdata[ST_PIN_OUT] = st_ff.pin_out;
          nxt_st.rsp.prdata[ST_DRIVE]   = ~st_ff.pin_oe_n;
          nxt_st.rsp.prdata[ST_RSV]     = st_ff.rsv_hit;
        end
      end
    end

    // writes land on the edge the master sees pready high
    if (done && APB_REQ.pwrite) begin
      if (hit_ctrl) begin
        // all eight bits are writable
        nxt_st.ctrl = APB_REQ.pwdata[7:0];
      end else if (hit_cfg) begin
        nxt_st.rx_en   = APB_REQ.pwdata[RXEN_LO +: 4];
        nxt_st.tx0_sel = APB_REQ.pwdata[TX0SEL_LO +: 4];
        nxt_st.tx1_sel = APB_REQ.pwdata[TX1SEL_LO +: 4];
      end
    end

    // pin driver follows the enable bit
    nxt_st.pin_oe_n = ~en;
    // a disabled pin is released and its data held low
    if (en) begin
      // with source status, select 0 this is the level bit
      nxt_st.pin_out = mux_lvl;
    end else begin
      nxt_st.pin_out = 1'b0;
    end

    // reserved code indication, live
    nxt_st.rsv_hit = mux_rsv;
  end

  // state register
  // a single clocked process whose reset branch loads
  // constants only
  // synchronous reset; the pin comes up released
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_ff          <= '0;
      st_ff.ctrl     <= CTRL_RST;
      st_ff.rx_en    <= RXEN_RST;
      st_ff.tx0_sel  <= TXSEL_RST;
      st_ff.tx1_sel  <= TXSEL_RST;
      st_ff.pin_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs, all straight from flops
  // no gate sits between a flop and a port, so the board sees
  // no glitch when several fields change together
  assign APB_RSP   = st_ff.rsp;
  assign PIN3_OUT  = st_ff.pin_out;
  assign PIN3_OE_N = st_ff.pin_oe_n;

endmodule

/* File: inc/posm_pkg.sv */
// package: constants, carriers and state types of the pin3 output mux
package posm_pkg;

  // apb address width and register indices (byte address = 4 * index)
  localparam int          APB_AW      = 12;
  localparam logic [7:0]  IDX_CTRL    = 8'h13;
  localparam logic [7:0]  IDX_PORTCFG = 8'h20;
  localparam logic [7:0]  IDX_STATUS  = 8'h21;

  // pin3_output_control field positions
  localparam int SEL_HI  = 7;
  localparam int SEL_LO  = 5;
  localparam int SRC_HI  = 4;
  localparam int SRC_LO  = 2;
  localparam int LVL_BIT = 1;
  localparam int EN_BIT  = 0;

  // port configuration field positions
  localparam int RXEN_LO  = 0;
  localparam int TX0SEL_LO = 4;
  localparam int TX1SEL_LO = 8;

  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [3:0] RXEN_RST  = 4'hF;
  localparam logic [3:0] TXSEL_RST = 4'hF;

  // source codes
  localparam logic [2:0] SRC_DEV = 3'h4;
  localparam logic [2:0] SRC_RSV = 3'h5;
  localparam logic [2:0] SRC_TX0 = 3'h6;
  localparam logic [2:0] SRC_TX1 = 3'h7;

  // select codes
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_2 = 3'h2;
  localparam logic [2:0] SEL_3 = 3'h3;
  localparam logic [2:0] SEL_4 = 3'h4;
  localparam logic [2:0] SEL_5 = 3'h5;
  localparam logic [2:0] SEL_6 = 3'h6;
  localparam logic [2:0] SEL_7 = 3'h7;

  // status register bit positions
  localparam int ST_PIN_IN  = 0;
  localparam int ST_PIN_OUT = 1;
  localparam int ST_DRIVE   = 2;
  localparam int ST_RSV     = 3;

  // per receive port status
  typedef struct packed {
    logic [3:0] remote_gpio;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } posm_rx_t;

  // per transmit port status
  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic synced;
    logic irq;
  } posm_tx_t;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } posm_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } posm_apb_rsp_t;

  // state of the top module apart from its synchroniser
  typedef struct packed {
    logic [7:0]    ctrl;
    logic [3:0]    rx_en;
    logic [3:0]    tx0_sel;
    logic [3:0]    tx1_sel;
    logic          pin_out;
    logic          pin_oe_n;
    logic          rsv_hit;
    posm_apb_rsp_t rsp;
  } posm_state_t;

  // state of the input synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } posm_sync_t;

  // byte address of a register index
  function automatic logic [APB_AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // and over masked bits; an empty mask yields one
  function automatic logic masked_and(input logic [3:0] v,
                                      input logic [3:0] m);
    masked_and = &(v | ~m);
  endfunction

  // or over masked bits; an empty mask yields zero
  function automatic logic masked_or(input logic [3:0] v,
                                     input logic [3:0] m);
    masked_or = |(v & m);
  endfunction

endpackage

/* File: core/posm_sync3.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module posm_sync3 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // asynchronous level in, filtered level out
  input  wire logic d_in,
  output wire logic q_out
);
  import posm_pkg::*;

  posm_sync_t st_ff;   // registered state
  posm_sync_t nxt_st;  // next state

  // shift chain; the level moves only when flops two and three agree
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.level = st_ff.s3;
    end
  end

  // synchronous reset to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_out = st_ff.level;
endmodule

/* File: sim/posm_pin3_properties.sv */
// checker: port-level properties of the pin3 output mux
`timescale 1ns/1ps
module posm_pin3_properties (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    RST,
  // apb
  input wire posm_pkg::posm_apb_req_t APB_REQ,
  input wire posm_pkg::posm_apb_rsp_t APB_RSP,
  // sources
  input wire posm_pkg::posm_rx_t      [3:0] RX_STAT,
  input wire posm_pkg::posm_tx_t      [1:0] TX_STAT,
  input wire logic                    FRAME_SYNC,
  // pin
  input wire logic                    PIN3_IN,
  input wire logic                    PIN3_OUT,
  input wire logic                    PIN3_OE_N
);
  import posm_pkg::*;
  // completed write to the control word
  wire logic       wr = APB_REQ.psel && APB_REQ.penable &&
                        APB_RSP.pready && APB_REQ.pwrite &&
                        APB_REQ.paddr == byte_addr(IDX_CTRL);
  logic [7:0]      ctrl_ff;  // shadow of the control word
  wire logic [7:0] rxv = RX_STAT[ctrl_ff[3:2]];
  // selected receive bit; the upper half counts down from lock
  wire logic       rx_bit = ctrl_ff[7] ? rxv[{1'b0, ~ctrl_ff[6:5]}]
                                       : rxv[{1'b1, ctrl_ff[6:5]}];
  // shadow follows writes exactly as the register does
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_ff <= 8'h00;
    end else if (wr) begin
      ctrl_ff <= APB_REQ.pwdata[7:0];
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  property p_rst;
    $fell(RST) |-> PIN3_OE_N && !PIN3_OUT && !APB_RSP.pready;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pin not idle after reset");
  property p_off;
    PIN3_OE_N |-> !PIN3_OUT;
  endproperty
  a_off: assert property (p_off)
    else $error("data on an undriven pin");
  property p_rdy;
    APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready |=> APB_RSP.pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("no answer to access phase");
  property p_pulse;
    APB_RSP.pready |=> !APB_RSP.pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than a cycle");
  property p_rdz;
    !APB_RSP.pready |-> APB_RSP.prdata == 32'h0 && !APB_RSP.pslverr;
  endproperty
  a_rdz: assert property (p_rdz)
    else $error("answer outside ready");
  property p_en;
    wr |-> ##2 PIN3_OE_N == !$past(APB_REQ.pwdata[0], 2);
  endproperty
  a_en: assert property (p_en)
    else $error("drive enable not applied");
  property p_lvl;
    wr && APB_REQ.pwdata[7:2] == 6'h04 && APB_REQ.pwdata[0] |->
      ##2 PIN3_OUT == $past(APB_REQ.pwdata[1], 2);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("local level not driven");
  property p_rsv;
    wr && APB_REQ.pwdata[4:2] == SRC_DEV && APB_REQ.pwdata[7:5] > SEL_4
      |-> ##2 !PIN3_OUT;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved select drives high");
  property p_rx;
    !ctrl_ff[4] && ctrl_ff[0] |=> PIN3_OUT == $past(rx_bit);
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive port bit not forwarded");
  property p_fs;
    ctrl_ff == 8'h91 |=> PIN3_OUT == $past(FRAME_SYNC);
  endproperty
  a_fs: assert property (p_fs)
    else $error("frame sync not forwarded");
  property p_tx;
    ctrl_ff == 8'h59 |=> PIN3_OUT == $past(TX_STAT[0].frame_valid);
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit frame valid not forwarded");
endmodule
bind posm_pin3_mux posm_pin3_properties u_chk (.CLK(CLK), .RST(RST),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .RX_STAT(RX_STAT),
  .TX_STAT(TX_STAT), .FRAME_SYNC(FRAME_SYNC), .PIN3_IN(PIN3_IN),
  .PIN3_OUT(PIN3_OUT), .PIN3_OE_N(PIN3_OE_N));

/* File: sim/posm_board.sv */
// board model: resolves the shared pin 3 wire
`timescale 1ns/1ps
module posm_board (
  // device side of the pin
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // board driver, used only while the device lets go
  input  wire logic drv_en,
  input  wire logic drv_val,
  // resolved wire level
  output wire logic pin
);
  // a pull-down holds the wire low when nobody drives it
  assign pin = !pin_oe_n ? pin_out : (drv_en ? drv_val : 1'b0);
endmodule

/* File: sim/tb.sv */
// testbench: apb sweep of every select code over every source code but the reserved one
`timescale 1ns/1ps
module tb;
  import posm_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  posm_apb_req_t    req = '0;
  posm_apb_rsp_t    rsp;
  posm_rx_t   [3:0] rx = '0;
  posm_tx_t   [1:0] tx = '0;
  logic             fs = 1'b0;
  logic             drv_en = 1'b0;
  logic             drv_val = 1'b0;
  logic [11:0]      cfg = 12'hFFF;  // mirror of port config
  logic             pin, pin_out, pin_oe_n;
  logic [31:0]      q;
  logic             e;
  logic [7:0]       ctl;
  int               n_fail = 0;
  int               checked = 0;
  int               cyc = 0;
  // stimulus patterns, second one the inverse of the first
  logic [31:0] rx_pat [4] = '{32'hA5C35A3C, 32'h5A3CA5C3, 32'hFFFFFFFF,
                              32'h12488421};
  logic [7:0]  tx_pat [4] = '{8'h5A, 8'hA5, 8'hFF, 8'h3C};
  logic [11:0] cf_pat [4] = '{12'h5A5, 12'hA5A, 12'h000, 12'hFFF};

  always #5 clk = ~clk;

  posm_pin3_mux DUT (.CLK(clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp),
    .RX_STAT(rx), .TX_STAT(tx), .FRAME_SYNC(fs), .PIN3_IN(pin),
    .PIN3_OUT(pin_out), .PIN3_OE_N(pin_oe_n));
  posm_board u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .drv_en(drv_en), .drv_val(drv_val), .pin(pin));

  // watchdog: the whole run needs under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task close_out();
    $display("counts: %0d checks, %0d mismatches", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask

  // one apb transfer; holds the request until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // expected pin level for a control word and the current sources
  function automatic logic ref_pin(input logic [7:0] c);
    logic [3:0] lk, ps, m;
    logic [7:0] v;
    int s;
    for (int i = 0; i < 4; i++) begin
      lk[i] = rx[i].lock;
      ps[i] = rx[i].pass;
    end
    v = rx[c[3:2]];
    s = c[7:5];
    m = c[2] ? cfg[11:8] : cfg[7:4];
    if (!c[0]) return 1'b0;
    if (!c[4]) return s < 4 ? v[4 + s] : v[7 - s];
    if (c[4:2] == 3'h5) return 1'b0;
    if (c[4:2] == 3'h4) begin
      case (s)
        0: return c[1];
        1: return |(lk & cfg[3:0]);
        2, 3: return &(ps | ~cfg[3:0]);
        4: return fs;
        default: return 1'b0;
      endcase
    end
    case (s)
      0: return &(ps | ~m);
      1: return |(ps & m);
      2: return tx[c[2]].frame_valid;
      3: return tx[c[2]].line_valid;
      4: return tx[c[2]].synced;
      5: return tx[c[2]].irq;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk(pin_oe_n, 1'b1);
    apb(1'b0, 12'h04C, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h080, 32'h0);
    chk(q, 32'hFFF);
    $display("test reset values done");
    apb(1'b1, 12'h04C, 32'hFFFFFFFF);
    apb(1'b0, 12'h04C, 32'h0);
    chk(q, 32'hFF);
    apb(1'b0, 12'h050, 32'h0);
    chk(q, 32'h0);
    chk(e, 1'b1);
    $display("test register access done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      rx <= rx_pat[k];
      tx <= tx_pat[k];
      fs <= k[0];
      cfg <= cf_pat[k];
      apb(1'b1, 12'h080, {20'h0, cf_pat[k]});
      for (int c = 0; c < 64; c++) begin
        // software never programs the reserved source code
        if (c[2:0] == SRC_RSV) begin
          continue;
        end
        ctl = {c[5:0], k[1], (k != 3) | c[3]};
        apb(1'b1, 12'h04C, {24'h0, ctl});
        repeat (2) @(posedge clk);
        if (!ctl[4]) begin
          chk(pin_out, ref_pin(ctl));
        end else if (ctl[4:2] == SRC_DEV) begin
          chk(pin_out, ref_pin(ctl));
        end else begin
          chk(pin_out, ref_pin(ctl));
        end
        chk(pin_oe_n, !ctl[0]);
        // status source with a reserved select raises the flag
        if (c[5:0] == 6'h2C) begin
          apb(1'b0, 12'h084, 32'h0);
          chk(q[ST_RSV], 1'b1);
        end
      end
      $display("test sweep %0d done", k);
    end
    apb(1'b1, 12'h04C, 32'h0);
    drv_en <= 1'b1;
    drv_val <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, 12'h084, 32'h0);
    chk(q[2:0], 3'h1);
    $display("test pin input done");
    apb(1'b1, 12'h04C, 32'h91);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h04C, 32'h0);
    chk(q, 32'h0);
    chk(pin_oe_n, 1'b1);
    $display("test second reset done");
    close_out();
  end
endmodule
